// file: mult_group_pkg.sv
// constants, types and decode function for the multiply group decoder
// ============================================================
// Overview of operation
// - opcode ce15 adds the shifted product to the accumulator.
// - upper byte 53 loads the product high half from the memory operand.
// - bytes 3c/3d/3f/3e/5b load multiplicand; plain, add, add+move, copy, subtract.
// - bytes 5d/5c are two-word multiply-accumulate, plain and with data move.
// - byte 38 signed multiply, cf unsigned, 101+13-bit constant immediate multiply.
// - byte 3a multiplies and adds previous product, 3b multiplies and subtracts.
// - ce14 copies product to accumulator, ce16 subtracts product from accumulator.
// - byte 7d stores product high half, 7c stores product low half.
// - upper fourteen bits 3382 set the product shift mode from bits 1:0.
// - byte 39 squares and adds previous product, 5a squares and subtracts.
// - compatibility level hides instructions absent from older generations.
package mult_group_pkg;

   // ============================================================
   // opcodes
   localparam logic [15:0] OPC_ADD_PRODUCT = 16'hce15;
   localparam logic [15:0] OPC_COPY_PRODUCT = 16'hce14;
   localparam logic [15:0] OPC_SUB_PRODUCT = 16'hce16;
   localparam logic [13:0] OPC_SET_SHIFT = 14'h3382;
   localparam logic [2:0] OPC_IMM_MULT = 3'h5;
   localparam logic [7:0] HI_LOAD_PH = 8'h53;
   localparam logic [7:0] HI_LOAD_T = 8'h3c;
   localparam logic [7:0] HI_LOAD_T_ACC = 8'h3d;
   localparam logic [7:0] HI_LOAD_T_MOVE = 8'h3f;
   localparam logic [7:0] HI_LOAD_T_COPY = 8'h3e;
   localparam logic [7:0] HI_LOAD_T_SUB = 8'h5b;
   localparam logic [7:0] HI_MAC = 8'h5d;
   localparam logic [7:0] HI_MAC_MOVE = 8'h5c;
   localparam logic [7:0] HI_MUL = 8'h38;
   localparam logic [7:0] HI_MUL_U = 8'hcf;
   localparam logic [7:0] HI_MUL_ADD = 8'h3a;
   localparam logic [7:0] HI_MUL_SUB = 8'h3b;
   localparam logic [7:0] HI_STORE_PH = 8'h7d;
   localparam logic [7:0] HI_STORE_PL = 8'h7c;
   localparam logic [7:0] HI_SQR_ADD = 8'h39;
   localparam logic [7:0] HI_SQR_SUB = 8'h5a;

   // ============================================================
   // field positions and reset values
   localparam int IND_BIT = 7;
   localparam int DP_MSB = 6;
   localparam int SHIFT_MSB = 1;
   localparam int K_MSB = 12;
   localparam logic [31:0] ACC_RST = 32'h0;
   localparam logic [31:0] PROD_RST = 32'h0;
   localparam logic [15:0] MCAND_RST = 16'h0;
   localparam logic [1:0] SHIFT_RST = 2'h0;
   localparam logic [6:0] DP_RST = 7'h0;

   // ============================================================
   // types
   typedef enum logic [4:0] {
      op_none, add_product_to_acc, load_product_high, load_multiplicand,
      load_multiplicand_accumulate, load_multiplicand_accumulate_move,
      load_multiplicand_copy_product, load_multiplicand_subtract, multiply_accumulate,
      multiply_accumulate_move, signed_multiply, unsigned_multiply, immediate_multiply,
      multiply_and_add_previous, multiply_and_sub_previous, copy_product_to_acc,
      subtract_product_from_acc, store_product_high, store_product_low, set_product_shift,
      square_accumulate, square_subtract
   } op_t;
   typedef enum logic [1:0] {acc_keep, acc_add, acc_sub, acc_load} acc_op_t;
   // tier_second: absent from the oldest generation; tier_full: absent from both older ones
   typedef enum logic [1:0] {tier_base, tier_second, tier_full} tier_t;
   typedef struct packed {
      op_t op;
      acc_op_t acc;
      logic mem_ref;
      logic two_word;
      tier_t tier;
   } decoded_t;
   typedef struct packed {
      logic valid;
      logic [15:0] data;
   } store_t;

   function automatic decoded_t mk(input op_t op, input acc_op_t acc, input logic mem, input tier_t tier);
      decoded_t d;
      d.op = op;
      d.acc = acc;
      d.mem_ref = mem;
      d.two_word = (op == multiply_accumulate) || (op == multiply_accumulate_move);
      d.tier = tier;
      return d;
   endfunction

   function automatic decoded_t decode_word(input logic [15:0] w);
      decoded_t d;
      logic [7:0] hi;
      d = mk(op_none, acc_keep, 1'b0, tier_base);
      hi = w[15:8];
      if (w == OPC_ADD_PRODUCT) d = mk(add_product_to_acc, acc_add, 1'b0, tier_base);
      else if (w == OPC_COPY_PRODUCT) d = mk(copy_product_to_acc, acc_load, 1'b0, tier_base);
      else if (w == OPC_SUB_PRODUCT) d = mk(subtract_product_from_acc, acc_sub, 1'b0, tier_base);
      else if (w[15:2] == OPC_SET_SHIFT) d = mk(set_product_shift, acc_keep, 1'b0, tier_second);
      else if (w[15:13] == OPC_IMM_MULT) d = mk(immediate_multiply, acc_keep, 1'b0, tier_base);
      else if (hi == HI_LOAD_PH) d = mk(load_product_high, acc_keep, 1'b1, tier_second);
      else if (hi == HI_LOAD_T) d = mk(load_multiplicand, acc_keep, 1'b1, tier_base);
      else if (hi == HI_LOAD_T_ACC) d = mk(load_multiplicand_accumulate, acc_add, 1'b1, tier_base);
      else if (hi == HI_LOAD_T_MOVE) d = mk(load_multiplicand_accumulate_move, acc_add, 1'b1, tier_base);
      else if (hi == HI_LOAD_T_COPY) d = mk(load_multiplicand_copy_product, acc_load, 1'b1, tier_second);
      else if (hi == HI_LOAD_T_SUB) d = mk(load_multiplicand_subtract, acc_sub, 1'b1, tier_second);
      else if (hi == HI_MAC) d = mk(multiply_accumulate, acc_add, 1'b1, tier_second);
      else if (hi == HI_MAC_MOVE) d = mk(multiply_accumulate_move, acc_add, 1'b1, tier_second);
      else if (hi == HI_MUL) d = mk(signed_multiply, acc_keep, 1'b1, tier_base);
      else if (hi == HI_MUL_U) d = mk(unsigned_multiply, acc_keep, 1'b1, tier_full);
      else if (hi == HI_MUL_ADD) d = mk(multiply_and_add_previous, acc_add, 1'b1, tier_full);
      else if (hi == HI_MUL_SUB) d = mk(multiply_and_sub_previous, acc_sub, 1'b1, tier_full);
      else if (hi == HI_STORE_PH) d = mk(store_product_high, acc_keep, 1'b1, tier_full);
      else if (hi == HI_STORE_PL) d = mk(store_product_low, acc_keep, 1'b1, tier_full);
      else if (hi == HI_SQR_ADD) d = mk(square_accumulate, acc_add, 1'b1, tier_second);
      else if (hi == HI_SQR_SUB) d = mk(square_subtract, acc_sub, 1'b1, tier_second);
      return d;
   endfunction

   // product as seen by the accumulator and the stores: 0 none, 1 left 1, 2 left 4, 3 right 6
   function automatic logic [31:0] product_shift(input logic [31:0] p, input logic [1:0] mode);
      logic [31:0] r;
      unique case (mode)
         2'h0: r = p;
         2'h1: r = {p[30:0], 1'b0};
         2'h2: r = {p[27:0], 4'h0};
         2'h3: r = {{6{p[31]}}, p[31:6]};
      endcase
      return r;
   endfunction

endpackage

// file: multiply_group_decoder.sv
// decoder and executor for the multiply, multiplicand and product instruction group
`timescale 1ns/1ps
module multiply_group_decoder (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   input wire logic [15:0] mem_data,
   input wire mult_group_pkg::tier_t compat_level,
   output logic need_word2,
   output logic [31:0] acc_q,
   output logic [31:0] product_q,
   output logic [15:0] multiplicand_q,
   output logic [1:0] product_shift_field_q,
   output mult_group_pkg::store_t store_q,
   output logic data_move_q,
   output logic indirect_q,
   output logic [6:0] dp_offset_q,
   output logic unavailable_q,
   output logic foreign_q
);
   // ============================================================
   // decode
   typedef enum logic {st_idle = 1'b0, st_word2 = 1'b1} state_t;
   state_t state_q;
   state_t state_d;
   mult_group_pkg::decoded_t dec;
   mult_group_pkg::decoded_t held_q;
   mult_group_pkg::decoded_t cur;
   logic [15:0] hold_mem_q;
   wire in_idle = (state_q == st_idle);
   assign dec = mult_group_pkg::decode_word(instr);
   wire recog = (dec.op != mult_group_pkg::op_none);
   // an instruction above the selected generation is refused and flagged unavailable, not foreign; its address mode is still captured
   wire avail = (dec.tier <= compat_level);
   wire take = instr_valid & in_idle;
   wire start2 = take & recog & avail & dec.two_word;
   wire fire = instr_valid & (in_idle ? (recog & avail & ~dec.two_word) : 1'b1);
   assign cur = in_idle ? dec : held_q;
   wire [15:0] operand = in_idle ? mem_data : hold_mem_q;
   assign need_word2 = ~in_idle;

   // ============================================================
   // datapath selection
   wire [31:0] ps = mult_group_pkg::product_shift(product_q, product_shift_field_q);
   wire is_sqr = cur.op inside {mult_group_pkg::square_accumulate, mult_group_pkg::square_subtract};
   wire is_mac = cur.op inside {mult_group_pkg::multiply_accumulate, mult_group_pkg::multiply_accumulate_move};
   wire is_imm = (cur.op == mult_group_pkg::immediate_multiply);
   wire is_uns = (cur.op == mult_group_pkg::unsigned_multiply);
   wire [15:0] k_ext = {{(15 - mult_group_pkg::K_MSB){instr[mult_group_pkg::K_MSB]}},
                        instr[mult_group_pkg::K_MSB:0]};
   // the second word of a two-word multiply carries the program-memory factor
   wire [15:0] mul_a = (is_sqr | is_mac) ? operand : multiplicand_q;
   wire [15:0] mul_b = is_mac ? instr : (is_imm ? k_ext : operand);
   wire [31:0] mul_p;
   wire mult_load = cur.op inside {mult_group_pkg::multiply_accumulate, mult_group_pkg::multiply_accumulate_move,
      mult_group_pkg::signed_multiply, mult_group_pkg::unsigned_multiply, mult_group_pkg::immediate_multiply,
      mult_group_pkg::multiply_and_add_previous, mult_group_pkg::multiply_and_sub_previous,
      mult_group_pkg::square_accumulate, mult_group_pkg::square_subtract};
   wire t_load = cur.op inside {mult_group_pkg::load_multiplicand, mult_group_pkg::load_multiplicand_accumulate,
      mult_group_pkg::load_multiplicand_accumulate_move, mult_group_pkg::load_multiplicand_copy_product,
      mult_group_pkg::load_multiplicand_subtract, mult_group_pkg::multiply_accumulate,
      mult_group_pkg::multiply_accumulate_move, mult_group_pkg::square_accumulate,
      mult_group_pkg::square_subtract};
   wire ph_load = (cur.op == mult_group_pkg::load_product_high);
   wire shift_load = (cur.op == mult_group_pkg::set_product_shift);
   wire st_hi = (cur.op == mult_group_pkg::store_product_high);
   wire st_lo = (cur.op == mult_group_pkg::store_product_low);
   wire moves = cur.op inside {mult_group_pkg::load_multiplicand_accumulate_move,
      mult_group_pkg::multiply_accumulate_move};

   product_multiplier #(.W(16)) u_mult (
      .a(mul_a),
      .b(mul_b),
      .is_unsigned(is_uns),
      .product(mul_p)
   );

   // previous product is used before the new one replaces it
   logic [31:0] acc_d;
   always_comb begin
      unique case (cur.acc)
         mult_group_pkg::acc_keep: acc_d = acc_q;
         mult_group_pkg::acc_add: acc_d = acc_q + ps;
         mult_group_pkg::acc_sub: acc_d = acc_q - ps;
         mult_group_pkg::acc_load: acc_d = ps;
      endcase
   end

   wire [31:0] prod_d = mult_load ? mul_p : (ph_load ? {operand, product_q[15:0]} : product_q);
   wire [15:0] store_data_d = st_hi ? ps[31:16] : ps[15:0];

   always_comb begin
      state_d = state_q;
      if (start2) begin
         state_d = st_word2;
      end else if (~in_idle & instr_valid) begin
         state_d = st_idle;
      end
   end

   // ============================================================
   // registers
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q <= st_idle;
         held_q <= '0;
         hold_mem_q <= mult_group_pkg::MCAND_RST;
      end else begin
         state_q <= state_d;
         if (start2) begin
            held_q <= dec;
            hold_mem_q <= mem_data;
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         acc_q <= mult_group_pkg::ACC_RST;
         product_q <= mult_group_pkg::PROD_RST;
         multiplicand_q <= mult_group_pkg::MCAND_RST;
         product_shift_field_q <= mult_group_pkg::SHIFT_RST;
      end else if (fire) begin
         acc_q <= acc_d;
         product_q <= prod_d;
         if (t_load) begin
            multiplicand_q <= operand;
         end
         if (shift_load) begin
            product_shift_field_q <= instr[mult_group_pkg::SHIFT_MSB:0];
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         store_q <= '0;
         data_move_q <= 1'b0;
         unavailable_q <= 1'b0;
         foreign_q <= 1'b0;
      end else begin
         store_q.valid <= fire & (st_hi | st_lo);
         store_q.data <= store_data_d;
         data_move_q <= fire & moves;
         unavailable_q <= take & recog & ~avail;
         foreign_q <= take & ~recog;
      end
   end

   // address mode is captured from the opcode word only, not the second word
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         indirect_q <= 1'b0;
         dp_offset_q <= mult_group_pkg::DP_RST;
      end else if (take & recog & dec.mem_ref) begin
         indirect_q <= instr[mult_group_pkg::IND_BIT];
         dp_offset_q <= instr[mult_group_pkg::IND_BIT] ? mult_group_pkg::DP_RST
                        : instr[mult_group_pkg::DP_MSB:0];
      end
   end

   // ============================================================
   // assertions
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   wire op1 = take & avail;
   prod_add_a: assert property (op1 && instr == mult_group_pkg::OPC_ADD_PRODUCT
      |=> acc_q == $past(acc_q) + $past(ps)) else $error("product not added");
   prod_high_a: assert property (op1 && instr[15:8] == mult_group_pkg::HI_LOAD_PH
      |=> product_q[31:16] == $past(mem_data) && $stable(product_q[15:0]))
      else $error("product high not loaded");
   mcand_sub_a: assert property (op1 && instr[15:8] == mult_group_pkg::HI_LOAD_T_SUB
      |=> multiplicand_q == $past(mem_data) && acc_q == $past(acc_q) - $past(ps))
      else $error("multiplicand subtract wrong");
   // the second word is taken at the edge before the one that shows need_word2 low
   mac_waits_a: assert property (op1 && instr[15:8] == mult_group_pkg::HI_MAC
      |=> need_word2 && $stable(acc_q) ##1 ($past(instr_valid) ? !need_word2 : need_word2))
      else $error("two-word sequence wrong");
   signed_mult_a: assert property (op1 && instr[15:8] == mult_group_pkg::HI_MUL
      |=> $signed(product_q) == $signed($past(multiplicand_q)) * $signed($past(mem_data)))
      else $error("signed product wrong");
   mult_sub_a: assert property (op1 && instr[15:8] == mult_group_pkg::HI_MUL_SUB
      |=> acc_q == $past(acc_q) - $past(ps)) else $error("previous product not subtracted");
   acc_sub_a: assert property (op1 && instr == mult_group_pkg::OPC_SUB_PRODUCT
      |=> acc_q == $past(acc_q) - $past(ps) && $stable(product_q)) else $error("product subtract wrong");
   store_high_a: assert property (op1 && instr[15:8] == mult_group_pkg::HI_STORE_PH
      |=> store_q.valid && store_q.data == $past(ps[31:16])) else $error("store high wrong");
   shift_mode_a: assert property (op1 && instr[15:2] == mult_group_pkg::OPC_SET_SHIFT
      |=> product_shift_field_q == $past(instr[1:0])) else $error("shift mode not set");
   square_add_a: assert property (op1 && instr[15:8] == mult_group_pkg::HI_SQR_ADD
      |=> $signed(product_q) == $signed($past(mem_data)) * $signed($past(mem_data))
      && acc_q == $past(acc_q) + $past(ps)) else $error("square wrong");
   compat_block_a: assert property (take && recog && !avail
      |=> unavailable_q && $stable(acc_q) && $stable(product_q) && !need_word2)
      else $error("hidden instruction executed");
   direct_page_a: assert property (take && recog && dec.mem_ref && !instr[7]
      |=> !indirect_q && dp_offset_q == $past(instr[6:0])) else $error("page offset wrong");

   mac_seen_c: cover property (start2 ##1 instr_valid);
   hidden_c: cover property (take && recog && !avail);
   sqr_then_store_c: cover property (op1 && instr[15:8] == mult_group_pkg::HI_SQR_SUB
      ##1 op1 && instr[15:8] == mult_group_pkg::HI_STORE_PL);
endmodule

// file: product_multiplier.sv
// 16 x 16 multiplier with per-call signed or unsigned operands
`timescale 1ns/1ps
module product_multiplier #(
   parameter int W = 16
) (
   input wire logic [W-1:0] a,
   input wire logic [W-1:0] b,
   input wire logic is_unsigned,
   output logic [2*W-1:0] product
);
   // one extra bit lets a single signed array serve both signednesses
   logic signed [W:0] a_ext;
   logic signed [W:0] b_ext;
   logic signed [2*W+1:0] full;
   assign a_ext = {a[W-1] & ~is_unsigned, a};
   assign b_ext = {b[W-1] & ~is_unsigned, b};
   assign full = a_ext * b_ext;
   assign product = full[2*W-1:0];
endmodule

// file: tb_multiply_group_decoder.sv
// self-checking testbench for the multiply group decoder
`timescale 1ns/1ps
module tb_multiply_group_decoder;
   // ============================================================
   // stimulus and observed signals
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic instr_valid = 1'b0;
   logic [15:0] instr = 16'h0;
   logic [15:0] mem_data = 16'h0;
   mult_group_pkg::tier_t compat_level = mult_group_pkg::tier_full;
   logic need_word2;
   logic [31:0] acc_q;
   logic [31:0] product_q;
   logic [15:0] multiplicand_q;
   logic [1:0] product_shift_field_q;
   mult_group_pkg::store_t store_q;
   logic data_move_q;
   logic indirect_q;
   logic [6:0] dp_offset_q;
   logic unavailable_q;
   logic foreign_q;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   // expected state, kept by the bench alone
   logic [31:0] macc = 32'h0;
   logic [31:0] mp = 32'h0;
   logic [15:0] mt = 16'h0;
   logic [1:0] mpm = 2'h0;
   logic mind = 1'b0;
   logic [6:0] mdp = 7'h0;

   multiply_group_decoder u_multiply_group_decoder (.mclk(mclk), .sys_rst(sys_rst), .instr_valid(instr_valid),
      .instr(instr), .mem_data(mem_data), .compat_level(compat_level), .need_word2(need_word2), .acc_q(acc_q),
      .product_q(product_q), .multiplicand_q(multiplicand_q), .product_shift_field_q(product_shift_field_q),
      .store_q(store_q), .data_move_q(data_move_q), .indirect_q(indirect_q), .dp_offset_q(dp_offset_q),
      .unavailable_q(unavailable_q), .foreign_q(foreign_q));

   initial begin
      forever #10 mclk = ~mclk;
   end

   // ============================================================
   // helpers
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         num_errors++;
         complete_run();
      end
   end

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   function automatic logic [31:0] shf(input logic [31:0] p, input logic [1:0] mode);
      case (mode)
         2'h0: return p;
         2'h1: return {p[30:0], 1'b0};
         2'h2: return {p[27:0], 4'h0};
         default: return {{6{p[31]}}, p[31:6]};
      endcase
   endfunction

   function automatic logic [31:0] mul(input logic [15:0] a, input logic [15:0] b, input logic u);
      logic [31:0] ea;
      logic [31:0] eb;
      ea = u ? {16'h0, a} : {{16{a[15]}}, a};
      eb = u ? {16'h0, b} : {{16{b[15]}}, b};
      return ea * eb;
   endfunction

   task automatic chk_state();
      chk("acc", macc, acc_q);
      chk("product", mp, product_q);
      chk("multiplicand", {16'h0, mt}, {16'h0, multiplicand_q});
      chk("shift_mode", {30'h0, mpm}, {30'h0, product_shift_field_q});
      chk("indirect", {31'h0, mind}, {31'h0, indirect_q});
      chk("dp_offset", {25'h0, mdp}, {25'h0, dp_offset_q});
   endtask

   // kind 0 executes, 1 is hidden by the compatibility level, 2 is outside the group
   task automatic issue(input logic [15:0] w, input logic [15:0] m, input int kind);
      logic [31:0] sp;
      logic [7:0] h;
      logic st;
      logic [15:0] sd;
      logic mv;
      sp = shf(mp, mpm);
      h = w[15:8];
      st = 1'b0;
      sd = 16'h0;
      mv = 1'b0;
      if (kind != 2 && h != 8'hce && w[15:13] != 3'h5) begin
         mind = w[7];
         mdp = w[7] ? 7'h0 : w[6:0];
      end
      if (kind == 0) begin
         if (w == 16'hce15) macc = macc + sp;
         else if (w == 16'hce14) macc = sp;
         else if (w == 16'hce16) macc = macc - sp;
         else if (w[15:2] == 14'h3382) mpm = w[1:0];
         else if (w[15:13] == 3'h5) mp = mul(mt, {{3{w[12]}}, w[12:0]}, 1'b0);
         else case (h)
            8'h53: mp[31:16] = m;
            8'h3c: mt = m;
            8'h3d, 8'h3f: begin
               mt = m;
               macc = macc + sp;
               mv = (h == 8'h3f);
            end
            8'h3e: begin mt = m; macc = sp; end
            8'h5b: begin mt = m; macc = macc - sp; end
            8'h38, 8'hcf: mp = mul(mt, m, h == 8'hcf);
            8'h3a: begin mp = mul(mt, m, 1'b0); macc = macc + sp; end
            8'h3b: begin mp = mul(mt, m, 1'b0); macc = macc - sp; end
            8'h7d: begin st = 1'b1; sd = sp[31:16]; end
            8'h7c: begin st = 1'b1; sd = sp[15:0]; end
            8'h39: begin mt = m; mp = mul(m, m, 1'b0); macc = macc + sp; end
            8'h5a: begin mt = m; mp = mul(m, m, 1'b0); macc = macc - sp; end
            default: ;
         endcase
      end
      @(posedge mclk);
      instr_valid <= 1'b1;
      instr <= w;
      mem_data <= m;
      @(posedge mclk);
      instr_valid <= 1'b0;
      #1;
      chk_state();
      chk("need_word2", 32'h0, {31'h0, need_word2});
      chk("store_valid", {31'h0, st}, {31'h0, store_q.valid});
      if (st) chk("store_data", {16'h0, sd}, {16'h0, store_q.data});
      chk("data_move", {31'h0, mv}, {31'h0, data_move_q});
      chk("unavailable", {31'h0, kind == 1}, {31'h0, unavailable_q});
      chk("foreign", {31'h0, kind == 2}, {31'h0, foreign_q});
      @(posedge mclk);
      #1;
      chk("pulses_end", 32'h0, {28'h0, store_q.valid, data_move_q, unavailable_q, foreign_q});
   endtask

   // second word follows at once, or after an idle cycle when gap is set
   task automatic mac_pair(input logic [15:0] w, input logic [15:0] m, input logic [15:0] w2, input logic gap);
      macc = macc + shf(mp, mpm);
      mt = m;
      mp = mul(m, w2, 1'b0);
      mind = w[7];
      mdp = w[7] ? 7'h0 : w[6:0];
      @(posedge mclk);
      instr_valid <= 1'b1;
      instr <= w;
      mem_data <= m;
      @(posedge mclk);
      instr_valid <= !gap;
      instr <= w2;
      #1;
      chk("need_word2_wait", 32'h1, {31'h0, need_word2});
      if (gap) begin
         @(posedge mclk);
         instr_valid <= 1'b1;
         #1;
         chk("need_word2_gap", 32'h1, {31'h0, need_word2});
      end
      @(posedge mclk);
      instr_valid <= 1'b0;
      #1;
      chk_state();
      chk("need_word2_done", 32'h0, {31'h0, need_word2});
      chk("mac_move", {31'h0, !w[8]}, {31'h0, data_move_q});
      @(posedge mclk);
      #1;
      chk("mac_move_end", 32'h0, {31'h0, data_move_q});
   endtask

   // ============================================================
   // scenarios
   task automatic t_multiply();
      issue(16'h3c12, 16'h0003, 0);
      issue(16'h3885, 16'hfffe, 0);
      issue(16'hcf7f, 16'hfffe, 0);
      issue(16'ha005, 16'h0000, 0);
      issue(16'hbfff, 16'h0000, 0);
      $display("test multiply done");
   endtask

   task automatic t_acc();
      issue(16'hce14, 16'h0000, 0);
      issue(16'hce15, 16'h0000, 0);
      issue(16'hce15, 16'h0000, 0);
      issue(16'hce16, 16'h0000, 0);
      $display("test accumulate done");
   endtask

   task automatic t_shift_store();
      issue(16'h3c00, 16'h0100, 0);
      issue(16'h3800, 16'h8123, 0);
      for (int i = 0; i < 4; i++) begin
         issue(16'hce08 | i[15:0], 16'h0000, 0);
         issue(16'h7d90, 16'h0000, 0);
         issue(16'h7c0f, 16'h0000, 0);
         issue(16'hce15, 16'h0000, 0);
      end
      issue(16'hce08, 16'h0000, 0);
      $display("test shift and store done");
   endtask

   task automatic t_load_group();
      logic [7:0] ops [11] = '{8'h3d, 8'h3f, 8'h3e, 8'h5b, 8'h53, 8'h3a, 8'h3b, 8'h39, 8'h5a, 8'h3c, 8'h38};
      for (int i = 0; i < 11; i++) begin
         issue({ops[i], i[0], 7'h55 - i[6:0]}, 16'h0321 + 16'h1f3 * i[15:0], 0);
      end
      $display("test load group done");
   endtask

   task automatic t_mac();
      mac_pair(16'h5d83, 16'h0007, 16'hfff0, 1'b0);
      mac_pair(16'h5c21, 16'h8102, 16'h0030, 1'b1);
      $display("test multiply accumulate done");
   endtask

   task automatic t_compat();
      @(posedge mclk);
      compat_level <= mult_group_pkg::tier_base;
      issue(16'hce0a, 16'h0000, 1);
      issue(16'hcf10, 16'h0005, 1);
      issue(16'h5d90, 16'h0005, 1);
      issue(16'h3c44, 16'h0009, 0);
      @(posedge mclk);
      compat_level <= mult_group_pkg::tier_second;
      issue(16'h7d11, 16'h0000, 1);
      issue(16'h5310, 16'h0abc, 0);
      @(posedge mclk);
      compat_level <= mult_group_pkg::tier_full;
      issue(16'h2000, 16'h0001, 2);
      issue(16'hce00, 16'h0001, 2);
      $display("test compatibility done");
   endtask

   initial begin
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      #1;
      chk_state();
      chk("store_valid_rst", 32'h0, {31'h0, store_q.valid});
      $display("test reset done");
      t_multiply();
      t_acc();
      t_shift_store();
      t_load_group();
      t_mac();
      t_compat();
      complete_run();
   end
endmodule
